// File: core/sscc_pkg.sv
// Purpose: Shared constants for the serial controller clocking and link core
// Assumes: 32-bit AHB-Lite register bus, 125 MHz hclk
// Notes:   Offsets are byte addresses of aligned 32-bit words
package sscc_pkg;

  localparam int          HCLK_PERIOD_NS = 8;
  localparam int          ADDR_W         = 8;
  localparam int          DIV_W          = 12;
  localparam logic [11:0] DIV_MAX        = 12'hfff;
  localparam logic [11:0] DIV_RST        = 12'h000;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CLKDIV   = 8'h04;
  localparam logic [7:0] OFF_RX_MODE  = 8'h10;
  localparam logic [7:0] OFF_TX_MODE  = 8'h14;
  localparam logic [7:0] OFF_RHR      = 8'h20;
  localparam logic [7:0] OFF_THR      = 8'h24;
  localparam logic [7:0] OFF_STATUS   = 8'h28;
  localparam logic [7:0] OFF_INT_STAT = 8'h30;
  localparam logic [7:0] OFF_INT_MASK = 8'h34;
  localparam logic [7:0] OFF_ID       = 8'h3c;

  // Control register bits
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Clock mode register layout, same for receiver and transmitter
  localparam int MODE_CKS_LSB   = 0;
  localparam int MODE_CKO       = 2;
  localparam int MODE_START_LSB = 4;
  localparam int MODE_LEN_LSB   = 8;
  localparam logic [15:0] MODE_RST   = 16'h1f00;
  localparam logic [15:0] MODE_WMASK = 16'h1ff7;

  // Bit clock sources
  localparam logic [1:0] CKS_DIV   = 2'h0;
  localparam logic [1:0] CKS_OTHER = 2'h1;
  localparam logic [1:0] CKS_PIN   = 2'h2;

  // Start conditions
  localparam logic [3:0] START_CONT  = 4'h0;
  localparam logic [3:0] START_OTHER = 4'h1;
  localparam logic [3:0] START_LOW   = 4'h2;
  localparam logic [3:0] START_HIGH  = 4'h3;
  localparam logic [3:0] START_FALL  = 4'h4;
  localparam logic [3:0] START_RISE  = 4'h5;
  localparam logic [3:0] START_EDGE  = 4'h6;

  // Status and interrupt bit positions
  localparam int ST_TX_READY = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_READY = 4;
  localparam int ST_RX_OVR   = 5;
  localparam int ST_RX_BUSY  = 8;
  localparam int ST_TX_BUSY  = 9;
  localparam int ST_DIV_ACT  = 10;
  localparam int INT_W       = 6;
  localparam logic [5:0] INT_VALID = 6'h33;

  // Arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0000_5c31;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {SSCC_IDLE, SSCC_WAIT, SSCC_SHIFT} sscc_state_e;

endpackage

// File: core/sscc_clk_div.sv
// Purpose: Common bit clock divider with 50 percent duty
// Assumes: Single hclk domain, asynchronous active-low reset
// Notes:   Output is a level sampled by the core, not a clock net
`timescale 1ns/1ns
module sscc_clk_div #(
  parameter int DIV_W = 12
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [DIV_W-1:0] div_count,
  input  wire logic             div_load,
  output logic                  div_clk
);
  import sscc_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic             clk_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      clk_reg <= 1'b0;
    end else if (div_load || div_count == '0) begin
      cnt_reg <= '0;
      clk_reg <= 1'b0;
    end else if (cnt_reg == div_count - {{(DIV_W-1){1'b0}}, 1'b1}) begin
      cnt_reg <= '0;
      clk_reg <= ~clk_reg;
    end else begin
      cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign div_clk = clk_reg;

endmodule // sscc_clk_div

// File: core/sscc_core.sv
// Purpose: Clocking and link core of a synchronous serial controller
// Assumes: Pins and DMA handshakes are synchronous to hclk
// Notes:   Bit clocks are sampled levels; edges become one-cycle enables
// Notes on behaviour
// - Divider count is 12 bits, at most 4095, dividing hclk by up to 8190.
// - A zero divider count keeps the divider idle with no divided clock.
// - Nonzero count gives a clock of hclk over twice the count.
// - Each high and low phase lasts exactly count hclk cycles.
// - One divided clock feeds both receiver and transmitter.
// - Transmit bit clock comes from its pin, the receive clock or the divider.
// - Receive bit clock comes from its pin, the transmit clock or the divider.
// - Each side may drive its own bit clock out on its clock pin.
// - Receiver and transmitter run apart with own clock, start and data.
// - Receiver may use the transmit clock and start with transmission.
// - Transmitter may use the receive clock and start with reception.
// - Each side starts automatically or on a chosen frame strobe event.
// - Two DMA handshakes move whole 32-bit words for receive and transmit.
// - One interrupt request output serves the whole core.
// - Continuous mode: transmit starts on a written word, receive on enable.
// - A word arriving before the last is read flags overrun and overwrites.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module sscc_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  output logic             rx_dma_req,
  input  wire logic        rx_dma_ack,
  output logic [31:0]      rx_dma_data,
  output logic             tx_dma_req,
  input  wire logic        tx_dma_ack,
  input  wire logic [31:0] tx_dma_data,
  input  wire logic        rx_clock_in,
  output logic             rx_clock_out,
  output logic             rx_clock_oe,
  input  wire logic        rx_fsync_in,
  input  wire logic        rx_data_in,
  input  wire logic        tx_clock_in,
  output logic             tx_clock_out,
  output logic             tx_clock_oe,
  input  wire logic        tx_fsync_in,
  output logic             tx_data_out
);
  import sscc_pkg::*;

  // Bus and register state
  logic                   hreadyout_reg;
  logic                   hresp_reg;
  logic [31:0]            hrdata_reg;
  logic                   wr_pend_reg;
  logic [ADDR_W-1:0]      waddr_reg;
  logic [1:0]             ctrl_reg;
  logic [DIV_W-1:0]       clk_mode_reg;
  logic [15:0]            rx_mode_reg;
  logic [15:0]            tx_mode_reg;
  logic [INT_W-1:0]       int_stat_reg;
  logic [INT_W-1:0]       int_mask_reg;
  logic                   irq_reg;
  // Link state
  logic [31:0]            receive_holding_reg;
  logic [31:0]            transmit_holding_reg;
  logic                   thr_empty_reg;
  logic                   rx_ready_reg;
  logic [31:0]            rx_shift_reg;
  logic [31:0]            tx_shift_reg;
  logic [4:0]             rx_cnt_reg;
  logic [4:0]             tx_bit_reg;
  logic                   tx_data_reg;
  logic                   rx_clk_reg;
  logic                   tx_clk_reg;
  logic                   rx_oe_reg;
  logic                   tx_oe_reg;
  logic                   rx_fs_reg;
  logic                   rx_fs_prev_reg;
  logic                   tx_fs_reg;
  logic                   tx_fs_prev_reg;
  logic                   rx_go_reg;
  logic                   tx_first;
  sscc_state_e            rx_state_reg;
  sscc_state_e            tx_state_reg;

  logic                   ahb_go;
  logic                   rhr_rd;
  logic                   thr_wr;
  logic [31:0]            thr_wdata;
  logic [31:0]            rd_mux;
  logic                   div_clk;
  logic                   div_load;
  logic [1:0]             rx_cks;
  logic [1:0]             tx_cks;
  logic [3:0]             rx_start_mode;
  logic [3:0]             tx_start_mode;
  logic [4:0]             rx_len;
  logic [4:0]             tx_len;
  logic                   rx_base;
  logic                   rx_lvl;
  logic                   tx_lvl;
  logic                   rx_rise;
  logic                   tx_fall;
  logic                   rx_start_hit;
  logic                   tx_start_hit;
  logic                   rx_take;
  logic                   tx_take;
  logic                   rx_done;
  logic                   tx_last;
  logic [INT_W-1:0]       int_event;
  logic [INT_W-1:0]       int_clear;
  logic [31:0]            status_word;

  function automatic logic start_hit(input logic [3:0] mode, input logic fs,
                                     input logic fs_prev, input logic other);
    logic hit;
    hit = 1'b0;
    case (mode)
      START_CONT:  hit = 1'b1;
      START_OTHER: hit = other;
      START_LOW:   hit = !fs;
      START_HIGH:  hit = fs;
      START_FALL:  hit = fs_prev & !fs;
      START_RISE:  hit = !fs_prev & fs;
      START_EDGE:  hit = fs ^ fs_prev;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Register bus slave: zero wait states, always OKAY
  assign ahb_go   = hsel && htrans[1] && hready;
  assign div_load = wr_pend_reg && waddr_reg == OFF_CLKDIV;
  assign rhr_rd   = (ahb_go && !hwrite && haddr[ADDR_W-1:0] == OFF_RHR) || rx_dma_ack;
  assign thr_wr   = (wr_pend_reg && waddr_reg == OFF_THR) || tx_dma_ack;
  assign thr_wdata = (wr_pend_reg && waddr_reg == OFF_THR) ? hwdata : tx_dma_data;
  assign int_clear = (wr_pend_reg && waddr_reg == OFF_INT_STAT) ?
                     hwdata[INT_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      wr_pend_reg   <= 1'b0;
      waddr_reg     <= '0;
      hrdata_reg    <= '0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      wr_pend_reg   <= ahb_go && hwrite;
      if (ahb_go) begin
        waddr_reg <= haddr[ADDR_W-1:0];
      end
      if (ahb_go && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  always_comb begin
    status_word              = '0;
    status_word[ST_TX_READY] = thr_empty_reg;
    status_word[ST_TX_EMPTY] = thr_empty_reg && tx_state_reg == SSCC_IDLE;
    status_word[ST_RX_READY] = rx_ready_reg;
    status_word[ST_RX_OVR]   = int_stat_reg[ST_RX_OVR];
    status_word[ST_RX_BUSY]  = rx_state_reg == SSCC_SHIFT;
    status_word[ST_TX_BUSY]  = tx_state_reg == SSCC_SHIFT;
    status_word[ST_DIV_ACT]  = clk_mode_reg != '0;
  end

  always_comb begin
    case (haddr[ADDR_W-1:0])
      OFF_CTRL:     rd_mux = {30'h0, ctrl_reg};
      OFF_CLKDIV:   rd_mux = {20'h0, clk_mode_reg};
      OFF_RX_MODE:  rd_mux = {16'h0, rx_mode_reg};
      OFF_TX_MODE:  rd_mux = {16'h0, tx_mode_reg};
      OFF_RHR:      rd_mux = receive_holding_reg;
      OFF_STATUS:   rd_mux = status_word;
      OFF_INT_STAT: rd_mux = {26'h0, int_stat_reg};
      OFF_INT_MASK: rd_mux = {26'h0, int_mask_reg};
      OFF_ID:       rd_mux = ID_VALUE;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= CTRL_RST;
      clk_mode_reg <= DIV_RST;
      rx_mode_reg  <= MODE_RST;
      tx_mode_reg  <= MODE_RST;
      int_mask_reg <= '0;
    end else if (wr_pend_reg) begin
      case (waddr_reg)
        OFF_CTRL:     ctrl_reg     <= hwdata[1:0];
        OFF_CLKDIV:   clk_mode_reg <= hwdata[DIV_W-1:0];
        OFF_RX_MODE:  rx_mode_reg  <= hwdata[15:0] & MODE_WMASK;
        OFF_TX_MODE:  tx_mode_reg  <= hwdata[15:0] & MODE_WMASK;
        OFF_INT_MASK: int_mask_reg <= hwdata[INT_W-1:0] & INT_VALID;
        default:      ctrl_reg     <= ctrl_reg;
      endcase
    end
  end

  // Interrupt: sticky events, write one to clear, set wins over clear
  assign int_event[ST_TX_READY] = tx_take && !thr_wr;
  assign int_event[ST_TX_EMPTY] = tx_last && thr_empty_reg;
  assign int_event[3:2]         = 2'h0;
  assign int_event[ST_RX_READY] = rx_done;
  assign int_event[ST_RX_OVR]   = rx_done && rx_ready_reg && !rhr_rd;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clear) | int_event;
      irq_reg      <= |(int_stat_reg & int_mask_reg);
    end
  end

  // Clock selection
  sscc_clk_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .div_count (clk_mode_reg),
    .div_load  (div_load),
    .div_clk   (div_clk)
  );

  assign rx_cks        = rx_mode_reg[MODE_CKS_LSB +: 2];
  assign tx_cks        = tx_mode_reg[MODE_CKS_LSB +: 2];
  assign rx_start_mode = rx_mode_reg[MODE_START_LSB +: 4];
  assign tx_start_mode = tx_mode_reg[MODE_START_LSB +: 4];
  assign rx_len        = rx_mode_reg[MODE_LEN_LSB +: 5];
  assign tx_len        = tx_mode_reg[MODE_LEN_LSB +: 5];

  // A side that borrows the other side's clock sees that side's own source
  assign rx_base = (rx_cks == CKS_PIN) ? rx_clock_in : div_clk;
  assign rx_lvl  = (rx_cks == CKS_OTHER) ?
                   ((tx_cks == CKS_PIN) ? tx_clock_in : div_clk) : rx_base;
  assign tx_lvl  = (tx_cks == CKS_PIN) ? tx_clock_in :
                   (tx_cks == CKS_OTHER) ? rx_base : div_clk;
  assign rx_rise = rx_lvl && !rx_clk_reg;
  assign tx_fall = !tx_lvl && tx_clk_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_clk_reg     <= 1'b0;
      tx_clk_reg     <= 1'b0;
      rx_oe_reg      <= 1'b0;
      tx_oe_reg      <= 1'b0;
      rx_fs_reg      <= 1'b0;
      rx_fs_prev_reg <= 1'b0;
      tx_fs_reg      <= 1'b0;
      tx_fs_prev_reg <= 1'b0;
    end else begin
      rx_clk_reg     <= rx_lvl;
      tx_clk_reg     <= tx_lvl;
      rx_oe_reg      <= rx_mode_reg[MODE_CKO];
      tx_oe_reg      <= tx_mode_reg[MODE_CKO];
      rx_fs_reg      <= rx_fsync_in;
      rx_fs_prev_reg <= rx_fs_reg;
      tx_fs_reg      <= tx_fsync_in;
      tx_fs_prev_reg <= tx_fs_reg;
    end
  end

  // Receiver follows the first transmit bit at once; the other way is one cycle late
  assign rx_start_hit = start_hit(rx_start_mode, rx_fs_reg, rx_fs_prev_reg, tx_first);
  assign tx_start_hit = start_hit(tx_start_mode, tx_fs_reg, tx_fs_prev_reg, rx_go_reg);
  assign rx_take = rx_state_reg == SSCC_WAIT && ctrl_reg[CTRL_RX_EN] && rx_start_hit;
  assign tx_take = tx_state_reg == SSCC_WAIT && ctrl_reg[CTRL_TX_EN] && tx_start_hit;
  assign rx_done = rx_state_reg == SSCC_SHIFT && ctrl_reg[CTRL_RX_EN] && rx_rise &&
                   rx_cnt_reg == rx_len;
  assign tx_last = tx_state_reg == SSCC_SHIFT && ctrl_reg[CTRL_TX_EN] && tx_fall &&
                   tx_bit_reg == 5'h00;
  assign tx_first = tx_state_reg == SSCC_SHIFT && ctrl_reg[CTRL_TX_EN] && tx_fall &&
                    tx_bit_reg == tx_len;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_go_reg <= 1'b0;
    end else begin
      rx_go_reg <= rx_take;
    end
  end

  // Transmit holding register, filled by software or DMA
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_holding_reg <= '0;
      thr_empty_reg        <= 1'b1;
    end else begin
      if (thr_wr) begin
        transmit_holding_reg <= thr_wdata;
        thr_empty_reg        <= 1'b0;
      end else if (tx_take) begin
        thr_empty_reg <= 1'b1;
      end
    end
  end

  // Transmitter: MSB first, bits change on falling bit clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= SSCC_IDLE;
      tx_shift_reg <= '0;
      tx_bit_reg   <= '0;
      tx_data_reg  <= 1'b0;
    end else begin
      case (tx_state_reg)
        SSCC_IDLE: begin
          if (ctrl_reg[CTRL_TX_EN] && !thr_empty_reg) begin
            tx_state_reg <= SSCC_WAIT;
          end
        end
        SSCC_WAIT: begin
          if (!ctrl_reg[CTRL_TX_EN]) begin
            tx_state_reg <= SSCC_IDLE;
          end else if (tx_take) begin
            tx_state_reg <= SSCC_SHIFT;
            tx_shift_reg <= transmit_holding_reg;
            tx_bit_reg   <= tx_len;
          end
        end
        SSCC_SHIFT: begin
          if (!ctrl_reg[CTRL_TX_EN]) begin
            tx_state_reg <= SSCC_IDLE;
          end else if (tx_fall) begin
            tx_data_reg <= tx_shift_reg[tx_bit_reg];
            if (tx_bit_reg == 5'h00) begin
              tx_state_reg <= SSCC_IDLE;
            end else begin
              tx_bit_reg <= tx_bit_reg - 5'h01;
            end
          end
        end
        default: tx_state_reg <= SSCC_IDLE;
      endcase
    end
  end

  // Receiver: samples on rising bit clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= SSCC_IDLE;
      rx_shift_reg <= '0;
      rx_cnt_reg   <= '0;
    end else begin
      case (rx_state_reg)
        SSCC_IDLE: begin
          if (ctrl_reg[CTRL_RX_EN]) begin
            rx_state_reg <= SSCC_WAIT;
          end
        end
        SSCC_WAIT: begin
          if (!ctrl_reg[CTRL_RX_EN]) begin
            rx_state_reg <= SSCC_IDLE;
          end else if (rx_take) begin
            rx_state_reg <= SSCC_SHIFT;
            rx_shift_reg <= '0;
            rx_cnt_reg   <= '0;
          end
        end
        SSCC_SHIFT: begin
          if (!ctrl_reg[CTRL_RX_EN]) begin
            rx_state_reg <= SSCC_IDLE;
          end else if (rx_done) begin
            rx_shift_reg <= '0;
            rx_cnt_reg   <= '0;
            if (rx_start_mode != START_CONT) begin
              rx_state_reg <= SSCC_WAIT;
            end
          end else if (rx_rise) begin
            rx_shift_reg <= {rx_shift_reg[30:0], rx_data_in};
            rx_cnt_reg   <= rx_cnt_reg + 5'h01;
          end
        end
        default: rx_state_reg <= SSCC_IDLE;
      endcase
    end
  end

  // Receive holding register; a new word always overwrites
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_holding_reg <= '0;
      rx_ready_reg        <= 1'b0;
    end else begin
      if (rx_done) begin
        receive_holding_reg <= {rx_shift_reg[30:0], rx_data_in};
        rx_ready_reg        <= 1'b1;
      end else if (rhr_rd) begin
        rx_ready_reg <= 1'b0;
      end
    end
  end

  assign hreadyout    = hreadyout_reg;
  assign hresp        = hresp_reg;
  assign hrdata       = hrdata_reg;
  assign irq          = irq_reg;
  assign rx_dma_req   = rx_ready_reg;
  assign rx_dma_data  = receive_holding_reg;
  assign tx_dma_req   = thr_empty_reg;
  assign rx_clock_out = rx_clk_reg;
  assign rx_clock_oe  = rx_oe_reg;
  assign tx_clock_out = tx_clk_reg;
  assign tx_clock_oe  = tx_oe_reg;
  assign tx_data_out  = tx_data_reg;

endmodule // sscc_core

// File: verif/sscc_core_props.sv
// Purpose: Port assertions for sscc_core
// Assumes: Single hclk domain, zero-wait register bus
// Notes:   Shadows follow CLKDIV and INT_MASK writes seen on the bus
`timescale 1ns/1ns
module sscc_core_props import sscc_pkg::*; (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        tx_dma_req,
  input wire logic        tx_dma_ack
);
  logic        wr_q;
  logic [7:0]  a_q;
  logic [11:0] div_sh;
  logic [5:0]  msk_sh;
  wire         rd_take = hsel && htrans[1] && hready && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      a_q    <= 8'h00;
      div_sh <= DIV_RST;
      msk_sh <= 6'h00;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      a_q  <= haddr[7:0];
      if (wr_q && a_q == OFF_CLKDIV) div_sh <= hwdata[11:0];
      if (wr_q && a_q == OFF_INT_MASK) msk_sh <= hwdata[5:0] & INT_VALID;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_id; rd_take && haddr[7:0] == OFF_ID |=> hrdata == ID_VALUE; endproperty
  a_id: assert property (p_id) else $error("id read wrong");
  property p_unmap; rd_take && haddr[7:0] == 8'h08 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_div_rd;
    rd_take && haddr[7:0] == OFF_CLKDIV |=> hrdata == {20'h0, $past(div_sh)};
  endproperty
  a_div_rd: assert property (p_div_rd) else $error("divider readback wrong");
  property p_div_act;
    rd_take && haddr[7:0] == OFF_STATUS |=> hrdata[ST_DIV_ACT] == ($past(div_sh) != 12'h0);
  endproperty
  a_div_act: assert property (p_div_act) else $error("divider active flag wrong");
  property p_mask_rd;
    rd_take && haddr[7:0] == OFF_INT_MASK |=> hrdata == {26'h0, $past(msk_sh)};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  property p_tx_ack; tx_dma_ack |=> !tx_dma_req; endproperty
  a_tx_ack: assert property (p_tx_ack) else $error("dma word not taken");
  property p_irq_off; msk_sh == 6'h0 && $past(msk_sh) == 6'h0 |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_irq_rise; $rose(irq) |-> $past(msk_sh) != 6'h0; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose with no mask");
  c_irq: cover property ($rose(irq));
  c_dma: cover property (tx_dma_ack);
  c_div: cover property (rd_take && haddr[7:0] == OFF_CLKDIV && div_sh != 12'h0);
endmodule // sscc_core_props

bind sscc_core sscc_core_props u_props (.*);

// File: verif/sscc_far_end.sv
// Purpose: Far-end codec model on the serial pins
// Assumes: Pin levels synchronous to hclk
// Notes:   Echoes transmit data; pin clock rests low outside run
`timescale 1ns/1ns
module sscc_far_end (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic tx_data_out,
  input  wire logic rx_clock_out,
  input  wire logic rx_clock_oe,
  input  wire logic tx_clock_out,
  input  wire logic tx_clock_oe,
  output logic      rx_clock_in,
  output logic      tx_clock_in,
  output logic      rx_fsync_in,
  output logic      tx_fsync_in,
  output logic      rx_data_in
);
  logic [1:0] cnt;
  logic       pclk;
  // Toggles every 4 hclk, an eighth of the bus rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 2'h0;
      pclk <= 1'b0;
    end else if (!run) begin
      cnt  <= 2'h0;
      pclk <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) pclk <= !pclk;
    end
  end
  assign rx_clock_in = rx_clock_oe ? rx_clock_out : pclk;
  assign tx_clock_in = tx_clock_oe ? tx_clock_out : pclk;
  assign rx_fsync_in = 1'b0;
  assign tx_fsync_in = 1'b0;
  assign rx_data_in  = tx_data_out;
endmodule // sscc_far_end

// File: verif/sscc_core_test.sv
// Purpose: Self-checking bench for sscc_core
// Assumes: Zero-wait AHB-Lite slave, far end echoes data
// Notes:   Register access by bus tasks, pins by the far-end model
`timescale 1ns/1ns
module sscc_core_test;
  import sscc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] tx_dma_data = 32'h0;
  logic        rx_dma_ack = 1'b0;
  logic        tx_dma_ack = 1'b0;
  logic        run = 1'b0;
  logic [31:0] v;
  wire logic        hreadyout, hresp, irq, rx_dma_req, tx_dma_req;
  wire logic [31:0] hrdata, rx_dma_data;
  wire logic        rx_clock_in, rx_clock_out, rx_clock_oe, rx_fsync_in, rx_data_in;
  wire logic        tx_clock_in, tx_clock_out, tx_clock_oe, tx_fsync_in, tx_data_out;
  wire logic        hready = hreadyout;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int k, ph, nr;
  sscc_core u_dut (.*);
  sscc_far_end u_far (.*);
  initial forever #4 hclk = ~hclk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(v, exp);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc(OFF_ID, ID_VALUE);
    rc(8'h08, 32'h0);
    rc(OFF_CLKDIV, {20'h0, DIV_RST});
    chk({irq, tx_dma_req, rx_dma_req}, 3'b010);
    bus(1'b1, OFF_CLKDIV, 32'h1fff);
    rc(OFF_CLKDIV, {20'h0, DIV_MAX});
    bus(1'b1, OFF_TX_MODE, 32'h4);
    bus(1'b1, OFF_RX_MODE, 32'h4);
    bus(1'b1, OFF_CLKDIV, 32'h3);
    for (k = 0; k < 20 && tx_clock_out !== 1'b1; k++) @(negedge hclk);
    for (ph = 0; ph < 2; ph++) begin
      v = {31'h0, tx_clock_out};
      for (k = 0; k < 20 && tx_clock_out === v[0]; k++) begin
        chk(rx_clock_out, tx_clock_out);
        @(negedge hclk);
      end
      chk(k, 3);
    end
    @(posedge hclk);
    bus(1'b1, OFF_CLKDIV, 32'h0);
    repeat (2) @(negedge hclk);
    for (k = 0; k < 10; k++) @(negedge hclk) chk(tx_clock_out, 1'b0);
    @(posedge hclk);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(v[ST_DIV_ACT], 1'b0);
    bus(1'b1, OFF_TX_MODE, 32'h2);
    bus(1'b1, OFF_RX_MODE, 32'h5);
    nr = 0;
    for (k = 0; k < 100; k++) begin
      @(posedge hclk);
      run <= (k < 64);
      #1;
      if (rx_clock_out === 1'b1 && v[0] === 1'b0) nr++;
      v[0] = rx_clock_out;
    end
    chk(nr, 8);
    chk({rx_clock_oe, tx_clock_oe}, 2'b10);
    @(posedge hclk);
    bus(1'b1, OFF_CLKDIV, 32'h2);
    bus(1'b1, OFF_TX_MODE, 32'h0700);
    bus(1'b1, OFF_RX_MODE, 32'h0711);
    bus(1'b1, OFF_INT_MASK, 32'h10);
    bus(1'b1, OFF_CTRL, 32'h3);
    bus(1'b1, OFF_THR, 32'ha5);
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(negedge hclk);
    chk(irq, 1'b1);
    @(posedge hclk);
    rc(OFF_RHR, 32'ha5);
    bus(1'b0, OFF_INT_STAT, 32'h0);
    chk(v[5:4], 2'b01);
    bus(1'b1, OFF_INT_STAT, 32'h33);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    @(posedge hclk);
    tx_dma_data <= 32'h3c;
    tx_dma_ack  <= 1'b1;
    @(posedge hclk);
    tx_dma_ack <= 1'b0;
    for (k = 0; k < 400 && rx_dma_req !== 1'b1; k++) @(negedge hclk);
    chk(rx_dma_data, 32'h3c);
    @(posedge hclk);
    bus(1'b1, OFF_THR, 32'h5a);
    v = 32'h0;
    for (k = 0; k < 60 && v[5] !== 1'b1; k++) bus(1'b0, OFF_INT_STAT, 32'h0);
    chk(v[5], 1'b1);
    chk(rx_dma_data, 32'h5a);
    bus(1'b1, OFF_INT_MASK, 32'h0);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    @(posedge hclk);
    rc(OFF_INT_MASK, 32'h0);
    @(posedge hclk);
    rx_dma_ack <= 1'b1;
    @(posedge hclk);
    rx_dma_ack <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    chk(rx_dma_req, 1'b0);
    @(posedge hclk);
    bus(1'b1, OFF_CTRL, 32'h0);
    rc(OFF_STATUS, 32'h423);
    close_out;
  end
endmodule // sscc_core_test
